/* verilog/pin_mux_pkg.sv */
// constants and types shared by the decoder / spi pin multiplexer
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // function choice of one shared pin when its spi select bit is clear
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FN_NONE,     // nothing routed, pin floats as an input
    FN_DECODER,  // quadrature decoder input
    FN_TIMER,    // timer b channel, bidirectional
    FN_GPIO      // port c general purpose bit
  } pin_func_t;

  // ---------------------------------------------------------------
  // peripheral_select_register fields
  // ---------------------------------------------------------------
  localparam int unsigned SEL_W          = 3;
  localparam int unsigned SEL_INDEX_BIT  = 0;  // index_pin_spi_select
  localparam int unsigned SEL_HOME_BIT   = 1;  // home_pin_spi_select
  localparam int unsigned SEL_PHASE_BIT  = 2;  // phase_a_pin_spi_select
  localparam logic [2:0]  SEL_RESET      = 3'h0;

  // ---------------------------------------------------------------
  // port_c_pullup_enable fields (one bit per port c pin)
  // ---------------------------------------------------------------
  localparam int unsigned PULL_W         = 4;
  localparam int unsigned PULL_PHASE_BIT = 0;
  localparam int unsigned PULL_INDEX_BIT = 2;
  localparam int unsigned PULL_HOME_BIT  = 3;
  localparam logic [3:0]  PULL_RESET     = 4'hf;

  // ---------------------------------------------------------------
  // function select word: two bits per pin
  // ---------------------------------------------------------------
  localparam int unsigned FUNC_W         = 6;
  localparam int unsigned FUNC_PHASE_LSB = 0;
  localparam int unsigned FUNC_INDEX_LSB = 2;
  localparam int unsigned FUNC_HOME_LSB  = 4;

  // ---------------------------------------------------------------
  // variant strap: cycles after reset release before it is trusted
  // ---------------------------------------------------------------
  localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

endpackage

/* verilog/pad_cell.sv */
// one shared pad: registered drive and a three-stage input filter
module pad_cell (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic drive_val,   // value to drive when enabled
  input  wire logic drive_en,    // high while this pad is driven
  input  wire logic pad_in,      // raw level seen at the pad
  output logic      pad_out_q,   // registered pad output value
  output logic      pad_oe_q,    // registered pad output enable
  output logic      level_q      // filtered pad level
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic s1_q, s2_q, s3_q;        // synchroniser chain
  logic level_d;                 // next filtered level

  // a change counts only once stages two and three agree;
  // stage one is read by stage two alone to keep metastability out
  always_comb begin
    level_d = level_q;
    if (s2_q == s3_q) begin
      level_d = s2_q;
    end
  end

  // registers: pads idle high because the pull-up holds them there
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q      <= 1'b1;
      s2_q      <= 1'b1;
      s3_q      <= 1'b1;
      level_q   <= 1'b1;
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
    end else begin
      s1_q      <= pad_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      level_q   <= level_d;
      pad_out_q <= drive_val;
      pad_oe_q  <= drive_en;
    end
  end

endmodule

/* verilog/decoder_spi_pin_mux.sv */
// function multiplexer for the decoder index, home and phase a pins
module decoder_spi_pin_mux (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // variant strap from a pin: high on the full-featured part
  input  wire logic        full_variant_strap,
  // software writes
  input  wire logic        sel_wr_en,
  input  wire logic [2:0]  sel_wr_data,
  input  wire logic        pull_wr_en,
  input  wire logic [3:0]  pull_wr_data,
  input  wire logic        func_wr_en,
  input  wire logic [5:0]  func_wr_data,
  // port c gpio block (bits 0, 2, 3 are used)
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_dir,
  // timer b channels
  input  wire logic        timer_b_channel_zero_out,
  input  wire logic        timer_b_channel_zero_oe,
  input  wire logic        timer_b_channel_two_out,
  input  wire logic        timer_b_channel_two_oe,
  input  wire logic        timer_b_channel_three_out,
  input  wire logic        timer_b_channel_three_oe,
  // spi 1 core
  input  wire logic        spi1_master_mode,
  input  wire logic        spi1_slave_out_data,
  input  wire logic        spi1_clock_out,
  // pads
  input  wire logic        decoder1_index_pin_in,
  output logic             decoder1_index_pin_out,
  output logic             decoder1_index_pin_oe,
  input  wire logic        decoder1_home_pin_in,
  output logic             decoder1_home_pin_out,
  output logic             decoder1_home_pin_oe,
  input  wire logic        phase_a_pin_in,
  output logic             phase_a_pin_out,
  output logic             phase_a_pin_oe,
  output logic [3:0]       port_c_pullup_en_q,
  // towards the peripherals
  output logic             decoder1_index_in_q,
  output logic             decoder1_home_in_q,
  output logic             decoder1_phase_a_in_q,
  output logic             timer_b_channel_zero_in_q,
  output logic             timer_b_channel_two_in_q,
  output logic             timer_b_channel_three_in_q,
  output logic             spi1_miso_in_q,
  output logic             spi1_selected_q,
  output logic             spi1_clock_in_q,
  output logic [3:0]       port_c_gpio_in_q,
  // readback of the control state
  output logic [2:0]       peripheral_select_register_q,
  output logic [5:0]       pin_function_q
);

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  logic [2:0] sel_d;                         // next spi select bits
  logic [3:0] pull_d;                        // next pull-up enables
  logic [5:0] func_d;                        // next function word
  logic [1:0] settle_q, settle_d;            // strap settle counter
  logic       init_done_q, init_done_d;      // reset default applied
  logic       st1_q, st2_q, st3_q;           // strap synchroniser
  logic       strap_q, strap_d;              // filtered strap level

  // filtered strap: agreement of stages two and three
  always_comb begin
    strap_d = strap_q;
    if (st2_q == st3_q) begin
      strap_d = st2_q;
    end
  end

  // next control values; software writes land one clock later
  always_comb begin
    sel_d       = peripheral_select_register_q;
    pull_d      = port_c_pullup_en_q;
    func_d      = pin_function_q;
    settle_d    = settle_q;
    init_done_d = init_done_q;
    if (!init_done_q) begin
      // the strap is caught only after it has had time to settle
      if (settle_q == pin_mux_pkg::STRAP_SETTLE) begin
        init_done_d = 1'b1;
        // read the filter's next value; its output flop is still one edge behind here
        if (strap_d) begin
          func_d[pin_mux_pkg::FUNC_PHASE_LSB +: 2] = pin_mux_pkg::FN_DECODER;
          func_d[pin_mux_pkg::FUNC_INDEX_LSB +: 2] = pin_mux_pkg::FN_DECODER;
          func_d[pin_mux_pkg::FUNC_HOME_LSB  +: 2] = pin_mux_pkg::FN_DECODER;
        end
        // reduced variant keeps FN_NONE until software picks one
      end else begin
        settle_d = settle_q + 2'h1;
      end
    end
    if (sel_wr_en) begin
      sel_d = sel_wr_data;
    end
    if (pull_wr_en) begin
      pull_d = pull_wr_data;
    end
    if (func_wr_en) begin
      // a write beats the reset default arriving in the same cycle
      func_d = func_wr_data;
    end
  end

  // control registers; async reset loads constants only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      peripheral_select_register_q <= pin_mux_pkg::SEL_RESET;
      port_c_pullup_en_q           <= pin_mux_pkg::PULL_RESET;
      pin_function_q               <= '0;
      settle_q                     <= 2'h0;
      init_done_q                  <= 1'b0;
      st1_q                        <= 1'b0;
      st2_q                        <= 1'b0;
      st3_q                        <= 1'b0;
      strap_q                      <= 1'b0;
    end else begin
      peripheral_select_register_q <= sel_d;
      port_c_pullup_en_q           <= pull_d;
      pin_function_q               <= func_d;
      settle_q                     <= settle_d;
      init_done_q                  <= init_done_d;
      st1_q                        <= full_variant_strap;
      st2_q                        <= st1_q;
      st3_q                        <= st2_q;
      strap_q                      <= strap_d;
    end
  end

  // ---------------------------------------------------------------
  // decoded routing
  // ---------------------------------------------------------------
  pin_mux_pkg::pin_func_t fn_index, fn_home, fn_phase;
  logic spi_index, spi_home, spi_phase;     // spi owns the pin
  logic lvl_index, lvl_home, lvl_phase;     // filtered pad levels
  logic slave_selected;                     // this slave addressed

  assign fn_index  = pin_mux_pkg::pin_func_t'(pin_function_q[pin_mux_pkg::FUNC_INDEX_LSB +: 2]);
  assign fn_home   = pin_mux_pkg::pin_func_t'(pin_function_q[pin_mux_pkg::FUNC_HOME_LSB +: 2]);
  assign fn_phase  = pin_mux_pkg::pin_func_t'(pin_function_q[pin_mux_pkg::FUNC_PHASE_LSB +: 2]);
  assign spi_index = peripheral_select_register_q[pin_mux_pkg::SEL_INDEX_BIT];
  assign spi_home  = peripheral_select_register_q[pin_mux_pkg::SEL_HOME_BIT];
  assign spi_phase = peripheral_select_register_q[pin_mux_pkg::SEL_PHASE_BIT];

  // select is active low; without the home pin routed nobody selects us
  assign slave_selected = spi_home && !spi1_master_mode && !lvl_home;

  // ---------------------------------------------------------------
  // pad drive: spi select bit wins over the function word
  // ---------------------------------------------------------------
  logic idx_val, idx_en, home_val, home_en, ph_val, ph_en;

  // index pin: miso, timer channel two, gpio bit 2 or decoder input
  always_comb begin
    idx_val = 1'b0;
    idx_en  = 1'b0;
    if (spi_index) begin
      if (!spi1_master_mode) begin
        // core shifts its bit out half a clock ahead of the sample edge;
        // one register of delay here stays well inside that half period
        idx_val = spi1_slave_out_data;
        idx_en  = slave_selected;
      end
    end else begin
      unique case (fn_index)
        pin_mux_pkg::FN_TIMER: begin
          idx_val = timer_b_channel_two_out;
          idx_en  = timer_b_channel_two_oe;
        end
        pin_mux_pkg::FN_GPIO: begin
          idx_val = gpio_out[pin_mux_pkg::PULL_INDEX_BIT];
          idx_en  = gpio_dir[pin_mux_pkg::PULL_INDEX_BIT];
        end
        pin_mux_pkg::FN_DECODER: begin
          idx_en  = 1'b0;
        end
        pin_mux_pkg::FN_NONE: begin
          idx_en  = 1'b0;
        end
      endcase
    end
  end

  // home pin: select input, timer channel three, gpio bit 3 or decoder
  always_comb begin
    home_val = 1'b0;
    home_en  = 1'b0;
    if (!spi_home) begin
      unique case (fn_home)
        pin_mux_pkg::FN_TIMER: begin
          home_val = timer_b_channel_three_out;
          home_en  = timer_b_channel_three_oe;
        end
        pin_mux_pkg::FN_GPIO: begin
          home_val = gpio_out[pin_mux_pkg::PULL_HOME_BIT];
          home_en  = gpio_dir[pin_mux_pkg::PULL_HOME_BIT];
        end
        pin_mux_pkg::FN_DECODER: begin
          home_en  = 1'b0;
        end
        pin_mux_pkg::FN_NONE: begin
          home_en  = 1'b0;
        end
      endcase
    end
  end

  // phase a pin: serial clock, timer channel zero, gpio bit 0, decoder
  always_comb begin
    ph_val = 1'b0;
    ph_en  = 1'b0;
    if (spi_phase) begin
      ph_val = spi1_clock_out;
      ph_en  = spi1_master_mode;
    end else begin
      unique case (fn_phase)
        pin_mux_pkg::FN_TIMER: begin
          ph_val = timer_b_channel_zero_out;
          ph_en  = timer_b_channel_zero_oe;
        end
        pin_mux_pkg::FN_GPIO: begin
          ph_val = gpio_out[pin_mux_pkg::PULL_PHASE_BIT];
          ph_en  = gpio_dir[pin_mux_pkg::PULL_PHASE_BIT];
        end
        pin_mux_pkg::FN_DECODER: begin
          ph_en  = 1'b0;
        end
        pin_mux_pkg::FN_NONE: begin
          ph_en  = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pad cells
  // ---------------------------------------------------------------
  pad_cell u_index (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .drive_val (idx_val),
    .drive_en  (idx_en),
    .pad_in    (decoder1_index_pin_in),
    .pad_out_q (decoder1_index_pin_out),
    .pad_oe_q  (decoder1_index_pin_oe),
    .level_q   (lvl_index)
  );

  pad_cell u_home (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .drive_val (home_val),
    .drive_en  (home_en),
    .pad_in    (decoder1_home_pin_in),
    .pad_out_q (decoder1_home_pin_out),
    .pad_oe_q  (decoder1_home_pin_oe),
    .level_q   (lvl_home)
  );

  pad_cell u_phase (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .drive_val (ph_val),
    .drive_en  (ph_en),
    .pad_in    (phase_a_pin_in),
    .pad_out_q (phase_a_pin_out),
    .pad_oe_q  (phase_a_pin_oe),
    .level_q   (lvl_phase)
  );

  // ---------------------------------------------------------------
  // inputs handed to the peripherals; unrouted ones read low
  // ---------------------------------------------------------------
  logic       dec_idx_d, dec_home_d, dec_ph_d;
  logic       tb0_d, tb2_d, tb3_d, miso_d, ssel_d, sclk_d;
  logic [3:0] gpio_in_d;

  always_comb begin
    dec_idx_d  = !spi_index && fn_index == pin_mux_pkg::FN_DECODER && lvl_index;
    dec_home_d = !spi_home  && fn_home  == pin_mux_pkg::FN_DECODER && lvl_home;
    dec_ph_d   = !spi_phase && fn_phase == pin_mux_pkg::FN_DECODER && lvl_phase;
    tb2_d      = !spi_index && fn_index == pin_mux_pkg::FN_TIMER && lvl_index;
    tb3_d      = !spi_home  && fn_home  == pin_mux_pkg::FN_TIMER && lvl_home;
    tb0_d      = !spi_phase && fn_phase == pin_mux_pkg::FN_TIMER && lvl_phase;
    miso_d     = spi_index && spi1_master_mode && lvl_index;
    // in master mode the core reads a low select as a rival master
    ssel_d     = spi_home && !lvl_home;
    sclk_d     = spi_phase && !spi1_master_mode && lvl_phase;
    gpio_in_d  = 4'h0;
    gpio_in_d[pin_mux_pkg::PULL_PHASE_BIT] = !spi_phase && fn_phase == pin_mux_pkg::FN_GPIO && lvl_phase;
    gpio_in_d[pin_mux_pkg::PULL_INDEX_BIT] = !spi_index && fn_index == pin_mux_pkg::FN_GPIO && lvl_index;
    gpio_in_d[pin_mux_pkg::PULL_HOME_BIT]  = !spi_home  && fn_home  == pin_mux_pkg::FN_GPIO && lvl_home;
  end

  // output registers towards the peripherals
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      decoder1_index_in_q        <= 1'b0;
      decoder1_home_in_q         <= 1'b0;
      decoder1_phase_a_in_q      <= 1'b0;
      timer_b_channel_zero_in_q  <= 1'b0;
      timer_b_channel_two_in_q   <= 1'b0;
      timer_b_channel_three_in_q <= 1'b0;
      spi1_miso_in_q             <= 1'b0;
      spi1_selected_q            <= 1'b0;
      spi1_clock_in_q            <= 1'b0;
      port_c_gpio_in_q           <= 4'h0;
    end else begin
      decoder1_index_in_q        <= dec_idx_d;
      decoder1_home_in_q         <= dec_home_d;
      decoder1_phase_a_in_q      <= dec_ph_d;
      timer_b_channel_zero_in_q  <= tb0_d;
      timer_b_channel_two_in_q   <= tb2_d;
      timer_b_channel_three_in_q <= tb3_d;
      spi1_miso_in_q             <= miso_d;
      spi1_selected_q            <= ssel_d;
      spi1_clock_in_q            <= sclk_d;
      port_c_gpio_in_q           <= gpio_in_d;
    end
  end

endmodule

/* verif/pin_mux_assertions.sv */
// concurrent checks on the ports of the decoder / spi pin multiplexer
module pin_mux_assertions (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       sel_wr_en,
  input wire logic [2:0] sel_wr_data,
  input wire logic       pull_wr_en,
  input wire logic [3:0] pull_wr_data,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_dir,
  input wire logic       timer_b_channel_three_oe,
  input wire logic       spi1_master_mode,
  input wire logic       spi1_slave_out_data,
  input wire logic       spi1_clock_out,
  input wire logic       decoder1_index_pin_out,
  input wire logic       decoder1_index_pin_oe,
  input wire logic       decoder1_home_pin_oe,
  input wire logic       phase_a_pin_out,
  input wire logic       phase_a_pin_oe,
  input wire logic [3:0] port_c_pullup_en_q,
  input wire logic       spi1_selected_q,
  input wire logic [2:0] peripheral_select_register_q,
  input wire logic [5:0] pin_function_q
);
  // -----------------------------------------------
  // one clock domain, reset disables every check
  // -----------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // writes land in the readback one edge later; the select register then holds
  chk_sel_write: assert property (sel_wr_en |=> peripheral_select_register_q == $past(sel_wr_data))
    else $error("select write not taken");
  chk_sel_hold: assert property (!sel_wr_en |=> $stable(peripheral_select_register_q))
    else $error("select register moved without a write");
  chk_pull_write: assert property (pull_wr_en |=> port_c_pullup_en_q == $past(pull_wr_data))
    else $error("pull-up write not taken");
  // pad flops follow the routing seen one edge earlier
  chk_home_input_only: assert property ($past(peripheral_select_register_q[1]) |-> !decoder1_home_pin_oe)
    else $error("select pin driven");
  chk_miso_master_in: assert property ($past(peripheral_select_register_q[0] && spi1_master_mode)
    |-> !decoder1_index_pin_oe)
    else $error("miso driven in master mode");
  chk_miso_slave_sel: assert property ($past(peripheral_select_register_q[0] && !spi1_master_mode)
    |-> decoder1_index_pin_oe == spi1_selected_q)
    else $error("miso drive differs from selection");
  chk_miso_slave_data: assert property ($past(peripheral_select_register_q[0] && !spi1_master_mode)
    && decoder1_index_pin_oe |-> decoder1_index_pin_out == $past(spi1_slave_out_data))
    else $error("miso bit late");
  chk_gpio_index: assert property ($past(pin_function_q[3:2] == 2'h3 && !peripheral_select_register_q[0])
    |-> decoder1_index_pin_oe == $past(gpio_dir[2])
    && (!decoder1_index_pin_oe || decoder1_index_pin_out == $past(gpio_out[2])))
    else $error("gpio drive wrong on index pin");
  chk_timer_home: assert property ($past(pin_function_q[5:4] == 2'h2 && !peripheral_select_register_q[1])
    |-> decoder1_home_pin_oe == $past(timer_b_channel_three_oe))
    else $error("timer enable wrong on home pin");
  chk_decoder_input: assert property ($past(pin_function_q[3:2] < 2'h2 && !peripheral_select_register_q[0])
    |-> !decoder1_index_pin_oe)
    else $error("decoder pin driven");
  chk_phase_clock: assert property ($past(peripheral_select_register_q[2] && spi1_master_mode)
    |-> phase_a_pin_oe && phase_a_pin_out == $past(spi1_clock_out))
    else $error("serial clock not driven");

  // main scenarios seen
  cov_slave_drive: cover property (decoder1_index_pin_oe && peripheral_select_register_q[0]);
  cov_selected: cover property (spi1_selected_q);
  cov_clock_out: cover property (phase_a_pin_oe && peripheral_select_register_q[2]);
endmodule

bind decoder_spi_pin_mux pin_mux_assertions u_chk (.sys_clk, .arst_n, .sel_wr_en, .sel_wr_data, .pull_wr_en,
  .pull_wr_data, .gpio_out, .gpio_dir, .timer_b_channel_three_oe, .spi1_master_mode, .spi1_slave_out_data,
  .spi1_clock_out, .decoder1_index_pin_out, .decoder1_index_pin_oe, .decoder1_home_pin_oe, .phase_a_pin_out,
  .phase_a_pin_oe, .port_c_pullup_en_q, .spi1_selected_q, .peripheral_select_register_q, .pin_function_q);

/* verif/spi_peer_model.sv */
// external spi peer and the wire level of the three shared pins
module spi_peer_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] dev_out,   // device pad values: 0 index, 1 home, 2 phase
  input  wire logic [2:0] dev_oe,    // device pad enables
  input  wire logic [2:0] pull_en,   // pull-ups of the same pins
  input  wire logic [2:0] peer_en,   // peer drives the pin
  input  wire logic [2:0] peer_val,  // peer value: miso, select (low active), clock
  output logic      [2:0] level      // resolved wire level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] last_q = 3'h0;  // last level, so a floating line never repeats it

  // -----------------------------------------------
  // wire resolution
  // -----------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (dev_oe[i] && peer_en[i]) begin
        level[i] = 1'bx;  // both drive: contention shows as unknown
      end else if (dev_oe[i]) begin
        level[i] = dev_out[i];
      end else if (peer_en[i]) begin
        level[i] = peer_val[i];
      end else if (pull_en[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = ~last_q[i];  // released line, no pull-up
      end
    end
  end

  // remember the last level of each pin
  always @(posedge sys_clk) begin
    last_q <= level;
  end
endmodule

/* verif/tb_decoder_spi_pin_mux.sv */
// self-checking bench for the decoder / spi pin multiplexer
module tb_decoder_spi_pin_mux;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(name, exp, got) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", name, exp, got); end end
  logic       sys_clk = 1'b0, arst_n = 1'b0, strap = 1'b1, master = 1'b1, slave_data = 1'b0, clk_out = 1'b1;
  logic       sel_wr_en = 1'b0, pull_wr_en = 1'b0, func_wr_en = 1'b0;
  logic [2:0] sel_wr_data = 3'h0, peer_en = 3'h0, peer_val = 3'h0;
  logic [3:0] pull_wr_data = 4'h0, gpio_out = 4'h0, gpio_dir = 4'h0;
  logic [5:0] func_wr_data = 6'h0;
  logic [1:0] t2 = 2'h0, t3 = 2'h0;  // timer channels as {oe, out}
  wire  [2:0] dev_out, dev_oe, lvl;
  wire  [3:0] pu, gpio_in;
  wire  [2:0] psr;
  wire  [5:0] func_q;
  wire        idx_in, home_in, t2_in, t3_in, miso_in, sel_q, sclk_in, ph_in, t0_in;
  int         n_fail = 0, checks = 0;

  // -----------------------------------------------
  // clock, device and peer
  // -----------------------------------------------
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  decoder_spi_pin_mux uut (.sys_clk(sys_clk), .arst_n(arst_n), .full_variant_strap(strap),
    .sel_wr_en(sel_wr_en), .sel_wr_data(sel_wr_data), .pull_wr_en(pull_wr_en), .pull_wr_data(pull_wr_data),
    .func_wr_en(func_wr_en), .func_wr_data(func_wr_data), .gpio_out(gpio_out), .gpio_dir(gpio_dir),
    .timer_b_channel_zero_out(1'b0), .timer_b_channel_zero_oe(1'b0), .timer_b_channel_two_out(t2[0]),
    .timer_b_channel_two_oe(t2[1]), .timer_b_channel_three_out(t3[0]), .timer_b_channel_three_oe(t3[1]),
    .spi1_master_mode(master), .spi1_slave_out_data(slave_data), .spi1_clock_out(clk_out),
    .decoder1_index_pin_in(lvl[0]), .decoder1_index_pin_out(dev_out[0]), .decoder1_index_pin_oe(dev_oe[0]),
    .decoder1_home_pin_in(lvl[1]), .decoder1_home_pin_out(dev_out[1]), .decoder1_home_pin_oe(dev_oe[1]),
    .phase_a_pin_in(lvl[2]), .phase_a_pin_out(dev_out[2]), .phase_a_pin_oe(dev_oe[2]),
    .port_c_pullup_en_q(pu), .decoder1_index_in_q(idx_in), .decoder1_home_in_q(home_in),
    .decoder1_phase_a_in_q(ph_in), .timer_b_channel_zero_in_q(t0_in), .timer_b_channel_two_in_q(t2_in),
    .timer_b_channel_three_in_q(t3_in), .spi1_miso_in_q(miso_in), .spi1_selected_q(sel_q),
    .spi1_clock_in_q(sclk_in), .port_c_gpio_in_q(gpio_in), .peripheral_select_register_q(psr),
    .pin_function_q(func_q));
  spi_peer_model peer (.sys_clk(sys_clk), .dev_out(dev_out), .dev_oe(dev_oe), .pull_en({pu[0], pu[3], pu[2]}),
    .peer_en(peer_en), .peer_val(peer_val), .level(lvl));

  // -----------------------------------------------
  // shared tasks
  // -----------------------------------------------
  // write 0 select, 1 pull-ups, 2 functions; returns once the pads follow
  task automatic wr(input int k, input logic [5:0] v);
    case (k)
      0: {sel_wr_en, sel_wr_data} = {1'b1, v[2:0]};
      1: {pull_wr_en, pull_wr_data} = {1'b1, v[3:0]};
      default: {func_wr_en, func_wr_data} = {1'b1, v};
    endcase
    @(negedge sys_clk);
    {sel_wr_en, pull_wr_en, func_wr_en} = 3'h0;
    @(negedge sys_clk);
  endtask
  // enough for the three-stage input filter plus output register
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // -----------------------------------------------
  // scenarios
  // -----------------------------------------------
  task automatic do_reset(input logic full);
    arst_n = 1'b0;
    strap = full;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    `CHK("function at release", 6'h00, func_q)
    repeat (8) @(negedge sys_clk);
    `CHK("default function", full ? 6'h15 : 6'h00, func_q)
    `CHK("spi selects", 3'h0, psr)
    `CHK("pull-ups", 4'hf, pu)
    `CHK("pad enables", 3'h0, dev_oe)
  endtask
  task automatic t_decoder();
    peer_en = 3'h3;
    peer_val = 3'h2;
    settle();
    `CHK("index to decoder", 3'h6, {ph_in, home_in, idx_in})
    peer_val = 3'h1;
    settle();
    `CHK("home to decoder", 3'h5, {ph_in, home_in, idx_in})
    peer_en = 3'h0;
  endtask
  task automatic t_gpio();
    gpio_dir = 4'hc;
    gpio_out = 4'h4;
    wr(2, 6'h3f);
    `CHK("gpio enables", 3'h3, dev_oe)
    `CHK("gpio values", 2'h1, dev_out[1:0])
    gpio_dir = 4'h4;  // index out, home in
    peer_en = 3'h2;
    peer_val = 3'h0;
    settle();
    `CHK("gpio split enables", 3'h1, dev_oe)
    `CHK("gpio inputs", 4'h5, gpio_in)
    gpio_dir = 4'h0;
  endtask
  task automatic t_timer();
    t2 = 2'h3;
    wr(2, 6'h2a);
    settle();
    `CHK("timer two drive", 2'h3, {dev_oe[0], dev_out[0]})
    `CHK("timer inputs", 3'h6, {t0_in, t2_in, t3_in})
    peer_en = 3'h0;
    t3 = 2'h2;
    @(negedge sys_clk);
    `CHK("timer three drive", 2'h2, {dev_oe[1], dev_out[1]})
  endtask
  task automatic t_pull();
    wr(1, 6'h03);
    `CHK("pull-ups cleared", 4'h3, pu)
    wr(1, 6'h0f);
  endtask
  task automatic t_spi_master();
    master = 1'b1;
    wr(0, 6'h07);
    peer_en = 3'h1;  // peer slave answers on miso now the spi select bit has taken the pin from timer channel two
    `CHK("select readback", 3'h7, psr)
    `CHK("master enables", 3'h4, dev_oe)
    `CHK("serial clock out", 1'b1, dev_out[2])
    settle();
    `CHK("miso low", 1'b0, miso_in)
    peer_val = 3'h1;
    settle();
    `CHK("miso high", 1'b1, miso_in)
  endtask
  task automatic t_spi_slave();
    master = 1'b0;
    slave_data = 1'b1;
    peer_en = 3'h6;  // peer master: select high, clock low
    peer_val = 3'h2;
    settle();
    `CHK("unselected", 4'h0, {sel_q, dev_oe})
    peer_val = 3'h0;
    settle();
    `CHK("selected drive", 5'h13, {sel_q, dev_oe, dev_out[0]})
    slave_data = 1'b0;
    @(negedge sys_clk);
    `CHK("miso bit", 1'b0, dev_out[0])
    peer_val = 3'h4;
    settle();
    `CHK("slave clock in", 1'b1, sclk_in)
    peer_en = 3'h0;
    wr(0, 6'h00);
    `CHK("selects cleared", 3'h3, dev_oe)
  endtask

  initial begin
    do_reset(1'b0);
    do_reset(1'b1);
    t_decoder();
    t_gpio();
    t_timer();
    t_pull();
    t_spi_master();
    t_spi_slave();
    stop_test();
  end
  // watchdog: the whole run needs well under 400 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_fail++;
    stop_test();
  end
endmodule
